/* inc/lar_pkg.sv */
// package: constants and types of the linear array readout sequencer
package lar_pkg;
  localparam int unsigned PIX_PER_SECTION = 384;
  localparam int unsigned PIX_TOTAL       = 768;
  localparam int unsigned PIX_IDX_W       = 9;
  localparam int unsigned RESET_CLOCKS    = 18;
  localparam int unsigned RST_CNT_W       = 5;
  localparam logic [PIX_IDX_W-1:0] PIX_LAST = 9'h17f;
  localparam logic [RST_CNT_W-1:0] RESET_CLOCKS_CNT = 5'h12;

  typedef struct packed {
    logic                 out_en;
    logic [PIX_IDX_W-1:0] pixel_idx;
  } lar_pixel_t;

  typedef struct packed {
    logic freeze;
    logic int_reset;
    logic carry;
  } lar_status_t;
endpackage : lar_pkg

/* verilog/lar_section.sv */
// one 384-pixel section: shift register, freeze, integrator reset, output select
`timescale 1ns/10ps
`default_nettype none
module lar_section (
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  input  wire logic                  sec_clk_i,
  input  wire logic                  start_i,
  input  wire logic                  freeze_i,
  output logic                       freeze_o,
  output logic                       int_reset_o,
  output logic                       carry_o,
  output lar_pkg::lar_pixel_t        pixel_o
);
  // ==========================================================
  // input synchronisers and edge detect
  logic [1:0] clk_sync_q, start_sync_q, frz_sync_q;
  logic       clk_prev_q, frz_prev_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clk_sync_q   <= 2'h0;
      start_sync_q <= 2'h0;
      frz_sync_q   <= 2'h0;
      clk_prev_q   <= 1'b0;
      frz_prev_q   <= 1'b0;
    end else begin
      clk_sync_q   <= {clk_sync_q[0], sec_clk_i};
      start_sync_q <= {start_sync_q[0], start_i};
      frz_sync_q   <= {frz_sync_q[0], freeze_i};
      clk_prev_q   <= clk_sync_q[1];
      frz_prev_q   <= frz_sync_q[1];
    end
  end
  wire clk_rise   = clk_sync_q[1] & ~clk_prev_q;
  wire frz_rise   = frz_sync_q[1] & ~frz_prev_q;
  wire start_seen = clk_rise & start_sync_q[1];

  // ==========================================================
  // 384-stage shift register
  logic [lar_pkg::PIX_PER_SECTION-1:0] shift_q;
  logic [lar_pkg::PIX_PER_SECTION:0]   shift_in;
  assign shift_in[0] = start_seen; // [R7]
  genvar g;
  generate
    for (g = 0; g < lar_pkg::PIX_PER_SECTION; g++) begin : g_stage
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          shift_q[g] <= 1'b0;
        end else if (clk_rise) begin
          shift_q[g] <= (g == 0) ? start_sync_q[1] : shift_in[g]; // [R10]
        end
      end
      if (g > 0) begin : g_link
        assign shift_in[g] = shift_q[g-1];
      end
    end
  endgenerate
  assign shift_in[lar_pkg::PIX_PER_SECTION] = shift_q[lar_pkg::PIX_PER_SECTION-1];

  // ==========================================================
  // pixel index, freeze, integrator reset
  logic [lar_pkg::PIX_IDX_W-1:0] idx_q;
  logic                          active_q, freeze_q, ireset_q;
  logic [lar_pkg::RST_CNT_W-1:0] rst_cnt_q;
  wire  carry_now = shift_q[lar_pkg::PIX_PER_SECTION-1];
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      idx_q     <= '0;
      active_q  <= 1'b0;
      freeze_q  <= 1'b0;
      ireset_q  <= 1'b0;
      rst_cnt_q <= '0;
    end else begin
      if (frz_rise) begin
        freeze_q  <= 1'b1; // [R3] [R11]
        ireset_q  <= 1'b1; // [R11]
        rst_cnt_q <= '0;
      end else if (clk_rise && ireset_q) begin
        if (rst_cnt_q == lar_pkg::RESET_CLOCKS_CNT - 5'h1) begin
          ireset_q <= 1'b0; // [R13]
          freeze_q <= 1'b0;
        end else begin
          rst_cnt_q <= rst_cnt_q + 5'h1; // [R4]
        end
      end
      if (clk_rise) begin
        if (start_sync_q[1]) begin
          active_q <= 1'b1; // [R12]
          idx_q    <= '0;
        end else if (active_q && idx_q == lar_pkg::PIX_LAST) begin
          active_q <= 1'b0; // [R15] [R18]
        end else if (active_q) begin
          idx_q <= idx_q + 9'h1; // [R12]
        end
      end
    end
  end
  assign freeze_o          = freeze_q;
  assign int_reset_o       = ireset_q;
  assign carry_o           = carry_now; // [R14]
  assign pixel_o.out_en    = active_q;
  assign pixel_o.pixel_idx = idx_q;
endmodule : lar_section
`default_nettype wire

/* verilog/lar_readout.sv */
// top: two-section linear array readout sequencer
`timescale 1ns/10ps
`default_nettype none
// Function
// [R1] two 384-pixel sections forming 768-pixel line
// [R2] sections read separately or chained together
// [R3] freeze starts/stops integration for all pixels
// [R4] section clock drives transfer, output, reset
// [R5] controller ties freeze inputs per wiring mode
// [R6] parallel: second freeze tied to second start
// [R7] start high sampled on clock rise begins
// [R8] first carry can start second section
// [R9] second carry chains or marks end
// [R10] start pulse walks 384-stage shift register
// [R11] freeze rising disconnects samples, starts reset
// [R12] one pixel presented per section clock
// [R13] integrator reset ends after 18 clocks
// [R14] carry asserted on 384th clock edge
// [R15] 385th edge ends carry, output off
// [R16] chained second carry at 768, ends 769
// [R17] next start after charge transfer wait
// [R18] analog output high-impedance outside output phase; code only drops out_en, pixel_idx keeps its last value
// [R19] charge transfer wait at least 20 us
// [R20] controller drops start before next edge
// [R21] controller samples outputs in shift order
module lar_readout (
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  input  wire logic                 section_clock_first_i,
  input  wire logic                 section_clock_second_i,
  input  wire logic                 start_in_first_i,
  input  wire logic                 start_in_second_i,
  input  wire logic                 freeze_first_i,
  input  wire logic                 freeze_second_i,
  output logic                      carry_out_first_o,
  output logic                      carry_out_second_o,
  output lar_pkg::lar_pixel_t       analog_out_first_o,
  output lar_pkg::lar_pixel_t       analog_out_second_o,
  output lar_pkg::lar_status_t      status_first_o,
  output lar_pkg::lar_status_t      status_second_o
);
  // ==========================================================
  // sections
  logic                carry1, carry2, frz1, frz2, irs1, irs2;
  lar_pkg::lar_pixel_t pix1, pix2;
  lar_section u_first (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .sec_clk_i   (section_clock_first_i), // [R4]
    .start_i     (start_in_first_i),
    .freeze_i    (freeze_first_i),
    .freeze_o    (frz1),
    .int_reset_o (irs1),
    .carry_o     (carry1),
    .pixel_o     (pix1)
  ); // [R1]
  lar_section u_second (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .sec_clk_i   (section_clock_second_i),
    .start_i     (start_in_second_i), // [R2] [R16]
    .freeze_i    (freeze_second_i),
    .freeze_o    (frz2),
    .int_reset_o (irs2),
    .carry_o     (carry2),
    .pixel_o     (pix2)
  ); // [R1]

  // ==========================================================
  // registered outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      carry_out_first_o   <= 1'b0;
      carry_out_second_o  <= 1'b0;
      analog_out_first_o  <= '0;
      analog_out_second_o <= '0;
      status_first_o      <= '0;
      status_second_o     <= '0;
    end else begin
      carry_out_first_o   <= carry1; // [R8]
      carry_out_second_o  <= carry2; // [R9]
      analog_out_first_o  <= pix1; // [R18]
      analog_out_second_o <= pix2; // [R18]
      status_first_o      <= '{freeze: frz1, int_reset: irs1, carry: carry1};
      status_second_o     <= '{freeze: frz2, int_reset: irs2, carry: carry2};
    end
  end
endmodule : lar_readout
`default_nettype wire

/* dv/lar_readout_assertions.sv */
// checker: timing relations at the readout ports
`timescale 1ns/10ps
`default_nettype none
module lar_readout_chk (
  input wire logic                 clk_i,
  input wire logic                 rst_i,
  input wire logic                 carry_out_first_o,
  input wire logic                 carry_out_second_o,
  input wire lar_pkg::lar_pixel_t  analog_out_first_o,
  input wire lar_pkg::lar_pixel_t  analog_out_second_o,
  input wire lar_pkg::lar_status_t status_first_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  carry_idx_a: assert property (carry_out_first_o |-> analog_out_first_o == 10'h37f)
    else $error("first carry off last pixel");
  carry_end_a: assert property ($rose(carry_out_first_o) |-> carry_out_first_o[*7]
    ##[1:2] !(carry_out_first_o || analog_out_first_o.out_en)) else $error("carry end");
  pix_step_a: assert property (analog_out_first_o.out_en && $past(analog_out_first_o.out_en)
    && $changed(analog_out_first_o) |-> analog_out_first_o.pixel_idx ==
    $past(analog_out_first_o.pixel_idx) + 9'h1) else $error("pixel step");
  first_pix_a: assert property ($rose(analog_out_first_o.out_en) |->
    analog_out_first_o.pixel_idx == 9'h0) else $error("first pixel index");
  rst_hold_a: assert property ($fell(status_first_o.int_reset) |->
    $past(status_first_o.int_reset, 136)) else $error("reset too short");
  rst_end_a: assert property ($rose(status_first_o.int_reset) |->
    ##[137:144] !status_first_o.int_reset) else $error("reset too long");
  freeze_rst_a: assert property ($rose(status_first_o.freeze) |->
    ##[0:1] status_first_o.int_reset) else $error("freeze without reset");
  carry2_idx_a: assert property (carry_out_second_o |-> analog_out_second_o == 10'h37f)
    else $error("second carry off last pixel");
endmodule : lar_readout_chk
bind lar_readout lar_readout_chk i_chk (.clk_i, .rst_i, .carry_out_first_o,
  .carry_out_second_o, .analog_out_first_o, .analog_out_second_o, .status_first_o);
`default_nettype wire

/* dv/lar_ctl_model.sv */
// partner: controller making section clock and start pulses
`timescale 1ns/10ps
`default_nettype none
module lar_ctl_model (
  input  wire logic clk_i,
  output var  logic sclk_o,
  output var  logic start_o
);
  initial sclk_o = 1'b0;
  initial start_o = 1'b0;
  // clock stands still between frames; 800 ns section clock period
  task automatic frame(input int n, input bit go);
    if (go) repeat (200) @(posedge clk_i);
    @(posedge clk_i);
    start_o <= go;
    for (int i = 0; i < n; i++) begin
      repeat (4) @(posedge clk_i);
      sclk_o <= 1'b1;
      repeat (4) @(posedge clk_i);
      sclk_o  <= 1'b0;
      start_o <= 1'b0;
    end
  endtask : frame
endmodule : lar_ctl_model
`default_nettype wire

/* dv/lar_readout_tb.sv */
// testbench: readout sequencer against controller model
`timescale 1ns/10ps
`default_nettype none
module lar_readout_tb;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic chain = 1'b0;
  logic sclk, start, c1, c2;
  lar_pkg::lar_pixel_t p1, p2, l1, l2;
  lar_pkg::lar_status_t s1, s2;
  int n_fail = 0;
  int n_compared = 0;
  int cnt1, cnt2;
  always #50 clk_i = ~clk_i;
  lar_ctl_model i_ctl (.clk_i(clk_i), .sclk_o(sclk), .start_o(start));
  lar_readout i_dut (.clk_i(clk_i), .rst_i(rst_i),
    .section_clock_first_i(sclk), .section_clock_second_i(sclk),
    .start_in_first_i(start), .start_in_second_i(chain ? c1 : start),
    .freeze_first_i(start), .freeze_second_i(start),
    .carry_out_first_o(c1), .carry_out_second_o(c2),
    .analog_out_first_o(p1), .analog_out_second_o(p2),
    .status_first_o(s1), .status_second_o(s2));
  // count presented pixels in shift order, sampled where outputs are settled
  always @(negedge clk_i) begin
    if (p1.out_en && p1 != l1) cnt1++;
    if (p2.out_en && p2 != l2) cnt2++;
    l1 <= p1;
    l2 <= p2;
  end
  task automatic settle;
    repeat (10) @(negedge clk_i);
  endtask : settle
  task automatic check(input string what, input logic [9:0] exp, input logic [9:0] got);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %s expected %0h seen %0h", what, exp, got);
    end
  endtask : check
  task automatic t_parallel;
    cnt1 = 0;
    cnt2 = 0;
    i_ctl.frame(385, 1'b1);
    settle();
    check("first pixels", 10'h180, 10'(cnt1));
    check("second pixels", 10'h180, 10'(cnt2));
    check("outputs off", 10'h0, {p1.out_en, p2.out_en, c1, c2});
    check("status idle", 10'h0, {s1, s2});
  endtask : t_parallel
  task automatic t_chain;
    @(posedge clk_i) chain <= 1'b1;
    cnt1 = 0;
    cnt2 = 0;
    i_ctl.frame(768, 1'b1);
    settle();
    check("carry held", 10'h3, {p2.out_en, c2});
    i_ctl.frame(1, 1'b0);
    settle();
    check("chain first", 10'h180, 10'(cnt1));
    check("chain second", 10'h180, 10'(cnt2));
    check("chain off", 10'h0, {p2.out_en, c2});
  endtask : t_chain
  task automatic wrap_up;
    if (n_fail == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : wrap_up
  initial begin
    #2500000;
    n_fail++;
    wrap_up();
  end
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    t_parallel();
    t_chain();
    wrap_up();
  end
endmodule : lar_readout_tb
`default_nettype wire
